// [ocm_unit.v]
// ocm_unit.v: three-channel output compare match unit of a 16-bit timer
// assumes: counter core outside gives count, tick, top and bottom strobes;
// cpu accesses arrive as one-cycle write strobes with an 8-bit data byte
//
// How it works
// - each channel compares count with its value
// - three independent channels A, B and C
// - match sets flag on next timer tick
// - enabled flag requests interrupt, cleared when serviced
// - writing one clears flag, zero ignored
// - channel A value gives top in some modes
// - double buffered in pwm, direct otherwise
// - buffer moves to active at top/bottom
// - cpu writes hit buffer when buffering active
// - value changes only by cpu; direct reads
// - high byte latched first, low writes all
// - force updates output, no flag, non-pwm
// - count write blocks matches next timer tick
// - action bits unbuffered, apply from next match
// - output state kept across mode change
// - reset clears output state to zero
// - nonzero action overrides port value, not direction
// - action zero leaves output unchanged
// - mode 0 normal, 4 and 12 clear-on-match
// - toggle action in clear-on-match toggles output
`timescale 1ns/1ps
`include "ocm_defines.vh"

module ocm_unit #(
    parameter WIDTH = 16
) (
    // clock, reset, enable
    input  wire             SYS_CLK,
    input  wire             RST,
    input  wire             CE,
    // counter core
    input  wire [WIDTH-1:0] TIMER_COUNT,
    input  wire             TIMER_TICK,
    input  wire             TIMER_TOP,
    input  wire             TIMER_BOTTOM,
    input  wire             TIMER_COUNT_WR,
    input  wire [WIDTH-1:0] CAPTURE_VALUE,
    // mode and per-channel settings
    input  wire [3:0]       WAVEFORM_SELECT,
    input  wire [5:0]       OUTPUT_ACTION_BITS,
    input  wire [2:0]       COMPARE_IRQ_ENABLE,
    input  wire [2:0]       COMPARE_IRQ_ACK,
    // cpu byte writes and flag clears
    input  wire [7:0]       CPU_DATA,
    input  wire [2:0]       COMPARE_VALUE_HIGH_WR,
    input  wire [2:0]       COMPARE_VALUE_LOW_WR,
    input  wire [2:0]       FLAG_WRITE,
    input  wire [2:0]       FORCE_COMPARE_STROBE,
    // port pin logic
    input  wire [2:0]       PORT_VALUE,
    input  wire [2:0]       COMPARE_PIN_DIRECTION_BIT,
    // cpu reads
    output reg  [7:0]       COMPARE_VALUE_HIGH_A,
    output reg  [7:0]       COMPARE_VALUE_LOW_A,
    output reg  [7:0]       COMPARE_VALUE_HIGH_B,
    output reg  [7:0]       COMPARE_VALUE_LOW_B,
    output reg  [7:0]       COMPARE_VALUE_HIGH_C,
    output reg  [7:0]       COMPARE_VALUE_LOW_C,
    // status and events
    output reg  [2:0]       COMPARE_MATCH_FLAG,
    output reg  [2:0]       COMPARE_IRQ,
    output reg  [2:0]       COMPARE_OUTPUT_STATE,
    // counter control
    output reg  [WIDTH-1:0] TOP_VALUE,
    output reg              CLEAR_ON_MATCH,
    // pins
    output reg  [2:0]       PIN_OUT,
    output reg  [2:0]       PIN_OE
);

    reg  [7:0]       temp_ff;     // shared high byte holding register
    reg              block_ff;    // count write seen, block next tick
    wire             block;       // matches blocked on this tick
    wire             pwm_mode;    // any of the thirteen pwm modes
    wire             dbuf_on;     // double buffering active
    reg              upd_point;   // top or bottom update point
    wire             clr_a;       // clear-on-match, top from channel A
    wire             clr_cap;     // clear-on-match, top from capture
    wire [3*WIDTH-1:0] vals;      // channel values as cpu sees them
    wire [3*WIDTH-1:0] actv;      // active compare registers behind the buffers
    wire [2:0]       match;       // raw comparator outputs
    wire [2:0]       flag;        // channel flags
    wire [2:0]       ostate;      // channel output states
    wire [2:0]       flag_clr;    // write-one clears
    genvar           g;

    // mode decode
    assign clr_a    = (WAVEFORM_SELECT == `OCM_WGM_CLR_A);
    assign clr_cap  = (WAVEFORM_SELECT == `OCM_WGM_CLR_CAP);
    assign pwm_mode = !(WAVEFORM_SELECT == `OCM_WGM_NORMAL) && !clr_a && !clr_cap;
    assign dbuf_on  = pwm_mode;
    assign flag_clr = FLAG_WRITE & CPU_DATA[2:0];

    // update point: top for phase correct modes, bottom otherwise
    always @* begin
        case (WAVEFORM_SELECT)
            4'h1, 4'h2, 4'h3, `OCM_WGM_PCO_CAP, `OCM_WGM_PCO_A:    upd_point = TIMER_TOP;
            default:                                             upd_point = TIMER_BOTTOM;
        endcase
    end

    // a count write blocks any match at the next timer tick, even stopped
    assign block = block_ff || TIMER_COUNT_WR;

    // high byte latch and blocking state
    always @(posedge SYS_CLK) begin
        if (RST) begin
            temp_ff  <= `OCM_TEMP_RST;
            block_ff <= 1'b0;
        end else if (CE) begin
            if (|COMPARE_VALUE_HIGH_WR) begin
                temp_ff <= CPU_DATA;
            end
            if (TIMER_COUNT_WR) begin
                block_ff <= 1'b1;
            end else if (TIMER_TICK) begin
                block_ff <= 1'b0;
            end
        end
    end

    // three identical channels
    generate
        for (g = 0; g < 3; g = g + 1) begin : gen_ch
            ocm_channel #(
                .WIDTH(WIDTH)
            ) u_ch (
                .clk       (SYS_CLK),
                .rst       (RST),
                .ce        (CE),
                .count     (TIMER_COUNT),
                .tick      (TIMER_TICK),
                .block     (block),
                .upd_point (upd_point),
                .dbuf_on   (dbuf_on),
                .pwm_mode  (pwm_mode),
                .action    (OUTPUT_ACTION_BITS[2*g+1:2*g]),
                .wr_low    (COMPARE_VALUE_LOW_WR[g]),
                .low_byte  (CPU_DATA),
                .high_byte (temp_ff),
                .flag_clr  (flag_clr[g]),
                .irq_ack   (COMPARE_IRQ_ACK[g]),
                .force_stb (FORCE_COMPARE_STROBE[g]),
                .value     (vals[WIDTH*g+WIDTH-1:WIDTH*g]),
                .active    (actv[WIDTH*g+WIDTH-1:WIDTH*g]),
                .match     (match[g]),
                .flag_ff   (flag[g]),
                .out_ff    (ostate[g])
            );
        end
    endgenerate

    // registered outputs: reads, flags, irqs, pins, top
    always @(posedge SYS_CLK) begin
        if (RST) begin
            COMPARE_VALUE_HIGH_A <= 8'h00;
            COMPARE_VALUE_LOW_A  <= 8'h00;
            COMPARE_VALUE_HIGH_B <= 8'h00;
            COMPARE_VALUE_LOW_B  <= 8'h00;
            COMPARE_VALUE_HIGH_C <= 8'h00;
            COMPARE_VALUE_LOW_C  <= 8'h00;
            COMPARE_MATCH_FLAG   <= 3'h0;
            COMPARE_IRQ          <= 3'h0;
            COMPARE_OUTPUT_STATE <= 3'h0;
            TOP_VALUE            <= `OCM_MAX;
            CLEAR_ON_MATCH       <= 1'b0;
            PIN_OUT              <= 3'h0;
            PIN_OE               <= 3'h0;
        end else if (CE) begin
            // high byte read straight from the register
            COMPARE_VALUE_HIGH_A <= vals[15:8];
            COMPARE_VALUE_LOW_A  <= vals[7:0];
            COMPARE_VALUE_HIGH_B <= vals[31:24];
            COMPARE_VALUE_LOW_B  <= vals[23:16];
            COMPARE_VALUE_HIGH_C <= vals[47:40];
            COMPARE_VALUE_LOW_C  <= vals[39:32];
            COMPARE_MATCH_FLAG   <= flag;
            COMPARE_IRQ          <= flag & COMPARE_IRQ_ENABLE;
            COMPARE_OUTPUT_STATE <= ostate;
            // top choice for the counter core
            case (WAVEFORM_SELECT)
                // active register, not the buffer, so in pwm modes top moves only at the update point
                `OCM_WGM_CLR_A, `OCM_WGM_PC_A, `OCM_WGM_PCO_A, `OCM_WGM_FAST_A:
                    TOP_VALUE <= actv[WIDTH-1:0];
                `OCM_WGM_CLR_CAP, `OCM_WGM_PC_CAP, `OCM_WGM_PCO_CAP, `OCM_WGM_FAST_CAP:
                    TOP_VALUE <= CAPTURE_VALUE;
                4'h1, 4'h5:
                    TOP_VALUE <= 16'h00ff;
                4'h2, 4'h6:
                    TOP_VALUE <= 16'h01ff;
                4'h3, 4'h7:
                    TOP_VALUE <= 16'h03ff;
                default:
                    TOP_VALUE <= `OCM_MAX;
            endcase
            // clear request for the counter at a top match in clear-on-match modes
            CLEAR_ON_MATCH <= (clr_a && match[0] && !block) ||
                              (clr_cap && (TIMER_COUNT == CAPTURE_VALUE) && !block);
            // pin override when action bits nonzero; direction from port
            PIN_OUT[0] <= (|OUTPUT_ACTION_BITS[1:0]) ? ostate[0] : PORT_VALUE[0];
            PIN_OUT[1] <= (|OUTPUT_ACTION_BITS[3:2]) ? ostate[1] : PORT_VALUE[1];
            PIN_OUT[2] <= (|OUTPUT_ACTION_BITS[5:4]) ? ostate[2] : PORT_VALUE[2];
            PIN_OE     <= COMPARE_PIN_DIRECTION_BIT;
        end
    end

endmodule

// [ocm_defines.vh]
// ocm_defines.vh: constants for the output compare match unit
// assumes: included by bare name from the design files, no other dependency
`ifndef OCM_DEFINES_VH
`define OCM_DEFINES_VH

// waveform mode codes
`define OCM_WGM_NORMAL     4'h0
`define OCM_WGM_CLR_A      4'h4
`define OCM_WGM_CLR_CAP    4'hc
`define OCM_WGM_PC_CAP     4'h8
`define OCM_WGM_PC_A       4'h9
`define OCM_WGM_PCO_CAP    4'ha
`define OCM_WGM_PCO_A      4'hb
`define OCM_WGM_FAST_CAP   4'he
`define OCM_WGM_FAST_A     4'hf

// output action encodings
`define OCM_ACT_NONE       2'h0
`define OCM_ACT_TOGGLE     2'h1
`define OCM_ACT_CLEAR      2'h2
`define OCM_ACT_SET        2'h3

// reset values
`define OCM_CMP_RST        16'h0000
`define OCM_OUT_RST        1'b0
`define OCM_TEMP_RST       8'h00

// channel indices
`define OCM_CH_A           2'h0
`define OCM_CH_B           2'h1
`define OCM_CH_C           2'h2

// fixed top of normal mode and the bottom value
`define OCM_MAX            16'hffff
`define OCM_BOTTOM         16'h0000

`endif

// [ocm_channel.v]
// ocm_channel.v: one compare channel: value, buffer, flag, output state
// assumes: shared high byte latch and qualifiers come from the top module
`timescale 1ns/1ps
`include "ocm_defines.vh"

module ocm_channel #(
    parameter WIDTH = 16
) (
    // clock and reset
    input  wire             clk,
    input  wire             rst,
    input  wire             ce,
    // counter view
    input  wire [WIDTH-1:0] count,
    input  wire             tick,
    input  wire             block,
    input  wire             upd_point,
    // mode
    input  wire             dbuf_on,
    input  wire             pwm_mode,
    input  wire [1:0]       action,
    // cpu write of the value
    input  wire             wr_low,
    input  wire [7:0]       low_byte,
    input  wire [7:0]       high_byte,
    // flag control
    input  wire             flag_clr,
    input  wire             irq_ack,
    input  wire             force_stb,
    // results
    output wire [WIDTH-1:0] value,
    output wire [WIDTH-1:0] active,
    output wire             match,
    output reg              flag_ff,
    output reg              out_ff
);

    reg  [WIDTH-1:0] cmp_ff;      // active compare register
    reg  [WIDTH-1:0] buf_ff;      // double buffer
    reg              pend_ff;     // match waiting for the next timer tick
    wire [WIDTH-1:0] wr_word;     // full word from a low byte write
    wire             do_act;      // apply output action now
    reg              nxt_out;     // next output state

    assign wr_word = {high_byte, low_byte};
    assign value   = dbuf_on ? buf_ff : cmp_ff;
    assign active  = cmp_ff; // what the comparator really uses
    assign match   = (count == cmp_ff);

    // match applied on a timer tick, or forced in non-pwm modes
    assign do_act = (tick && pend_ff && !block) || (force_stb && !pwm_mode);

    // output action decode
    always @* begin
        case (action)
            `OCM_ACT_NONE:   nxt_out = out_ff;
            `OCM_ACT_TOGGLE: nxt_out = ~out_ff;
            `OCM_ACT_CLEAR:  nxt_out = 1'b0;
            `OCM_ACT_SET:    nxt_out = 1'b1;
            default:         nxt_out = out_ff;
        endcase
    end

    // compare value and buffer: set by cpu writes; in pwm modes the buffer moves to the compare value at the update point
    always @(posedge clk) begin
        if (rst) begin
            cmp_ff <= `OCM_CMP_RST;
            buf_ff <= `OCM_CMP_RST;
        end else if (ce) begin
            if (wr_low && dbuf_on) begin
                buf_ff <= wr_word;
            end
            if (wr_low && !dbuf_on) begin
                cmp_ff <= wr_word;
            end else if (dbuf_on && tick && upd_point) begin
                cmp_ff <= buf_ff;
            end
        end
    end

    // match pending, flag and output state
    always @(posedge clk) begin
        if (rst) begin
            pend_ff <= 1'b0;
            flag_ff <= 1'b0;
            out_ff  <= `OCM_OUT_RST;
        end else if (ce) begin
            if (tick) begin
                pend_ff <= match && !block;
            end
            // set wins over a clear in the same cycle
            if (tick && pend_ff && !block) begin
                flag_ff <= 1'b1;
            end else if (flag_clr || irq_ack) begin
                flag_ff <= 1'b0;
            end
            if (do_act) begin
                out_ff <= nxt_out;
            end
        end
    end

endmodule

// [ocm_unit_props.sv]
// ocm_unit_props.sv: port-level checks for ocm_unit
// assumes: bound onto ocm_unit, one clock, RST synchronous active high
`timescale 1ns/1ps
module ocm_unit_props #(
    parameter WIDTH = 16
) (
    // clock and qualifiers
    input logic             SYS_CLK,
    input logic             RST,
    input logic             CE,
    input logic             TIMER_TICK,
    // settings and strobes
    input logic [3:0]       WAVEFORM_SELECT,
    input logic [5:0]       OUTPUT_ACTION_BITS,
    input logic [2:0]       COMPARE_IRQ_ENABLE,
    input logic [7:0]       CPU_DATA,
    input logic [2:0]       COMPARE_VALUE_LOW_WR,
    input logic [2:0]       FLAG_WRITE,
    input logic [2:0]       FORCE_COMPARE_STROBE,
    input logic [2:0]       COMPARE_PIN_DIRECTION_BIT,
    // results
    input logic [7:0]       COMPARE_VALUE_LOW_A,
    input logic [2:0]       COMPARE_MATCH_FLAG,
    input logic [2:0]       COMPARE_IRQ,
    input logic [2:0]       COMPARE_OUTPUT_STATE,
    input logic [WIDTH-1:0] TOP_VALUE,
    input logic [2:0]       PIN_OUT,
    input logic [2:0]       PIN_OE
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    // output states leave reset low
    a_rst_clears: assert property ($fell(RST) |-> COMPARE_OUTPUT_STATE == 3'h0)
        else $error("state not low after reset");
    // request is flag gated by enable, same lag as the flag
    a_irq_follows: assert property ($past(CE) && !$past(RST) |->
        COMPARE_IRQ == (COMPARE_MATCH_FLAG & $past(COMPARE_IRQ_ENABLE))) else $error("irq mismatch");
    // a one in the flag position clears it, no tick to race it
    a_flag_clear: assert property (CE && FLAG_WRITE[0] && CPU_DATA[0] && !TIMER_TICK |->
        ##2 !COMPARE_MATCH_FLAG[0]) else $error("flag not cleared");
    // low byte lands two cycles later on the read port
    a_value_load: assert property (CE && COMPARE_VALUE_LOW_WR[0] |->
        ##2 COMPARE_VALUE_LOW_A == $past(CPU_DATA, 2)) else $error("low byte not loaded");
    // forced match with set action drives the state high
    a_force_sets: assert property (CE && FORCE_COMPARE_STROBE[0] && WAVEFORM_SELECT == 4'h0 &&
        OUTPUT_ACTION_BITS[1:0] == 2'h3 |-> ##2 COMPARE_OUTPUT_STATE[0]) else $error("force did not set");
    // no action means the state holds
    a_idle_keeps: assert property ($past(OUTPUT_ACTION_BITS[1:0], 2) == 2'h0 && !$past(RST, 2) &&
        !$past(RST) |-> $stable(COMPARE_OUTPUT_STATE[0])) else $error("state moved with no action");
    // active action replaces port value, direction untouched
    a_pin_override: assert property ($past(CE) && !$past(RST) && $past(OUTPUT_ACTION_BITS[1:0]) != 2'h0 |->
        PIN_OUT[0] == COMPARE_OUTPUT_STATE[0] && PIN_OE == $past(COMPARE_PIN_DIRECTION_BIT))
        else $error("pin not overridden");
    // clear-on-match mode takes top from channel a
    a_top_ctc: assert property ($past(WAVEFORM_SELECT) == 4'h4 && $past(WAVEFORM_SELECT, 2) == 4'h4 &&
        !$past(RST, 2) |-> TOP_VALUE[7:0] == COMPARE_VALUE_LOW_A) else $error("top not from channel a");
endmodule

bind ocm_unit ocm_unit_props #(.WIDTH(WIDTH)) u_props (
    .SYS_CLK(SYS_CLK), .RST(RST), .CE(CE), .TIMER_TICK(TIMER_TICK),
    .WAVEFORM_SELECT(WAVEFORM_SELECT), .OUTPUT_ACTION_BITS(OUTPUT_ACTION_BITS),
    .COMPARE_IRQ_ENABLE(COMPARE_IRQ_ENABLE), .CPU_DATA(CPU_DATA),
    .COMPARE_VALUE_LOW_WR(COMPARE_VALUE_LOW_WR), .FLAG_WRITE(FLAG_WRITE),
    .FORCE_COMPARE_STROBE(FORCE_COMPARE_STROBE), .COMPARE_PIN_DIRECTION_BIT(COMPARE_PIN_DIRECTION_BIT),
    .COMPARE_VALUE_LOW_A(COMPARE_VALUE_LOW_A), .COMPARE_MATCH_FLAG(COMPARE_MATCH_FLAG),
    .COMPARE_IRQ(COMPARE_IRQ), .COMPARE_OUTPUT_STATE(COMPARE_OUTPUT_STATE),
    .TOP_VALUE(TOP_VALUE), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE));

// [ocm_cpu_model.sv]
// ocm_cpu_model.sv: cpu side of the byte bus, one strobe per request
// assumes: requests come from the bench, strobes launch on falling edges
`timescale 1ns/1ps
module ocm_cpu_model (
    // clock and request
    input  logic       clk,
    input  logic       req,
    input  logic [1:0] kind,
    input  logic [2:0] sel,
    input  logic [7:0] dat,
    // byte bus to the unit
    output logic [7:0] data,
    output logic [2:0] hi_wr,
    output logic [2:0] lo_wr,
    output logic [2:0] flag_wr,
    output logic [2:0] force_wr
);
    // strobe lasts one cycle; idle data flips so stale bytes never look valid
    always @(negedge clk) begin
        data     <= req ? dat : ~data;
        hi_wr    <= (req && kind == 2'h0) ? sel : 3'h0;
        lo_wr    <= (req && kind == 2'h1) ? sel : 3'h0;
        flag_wr  <= (req && kind == 2'h2) ? sel : 3'h0;
        force_wr <= (req && kind == 2'h3) ? sel : 3'h0;
    end
endmodule

// [ocm_unit_bench.sv]
// ocm_unit_bench.sv: self-checking bench for the compare unit
// assumes: ocm_unit, ocm_cpu_model and the bound checker compiled first
`timescale 1ns/1ps
module ocm_unit_bench;
    // design and partner nets
    logic        clk, rst, ce, tick, top, bot, cnt_wr, clr, req;
    logic [15:0] cnt, cap, top_val;
    logic [3:0]  ws;
    logic [5:0]  act;
    logic [7:0]  data, dat, ha, la, hb, lb, hc, lc;
    logic [2:0]  ien, ack, hw, lw, fw, fo, pv, dir, flag, irq, st, pout, poe, sel;
    logic [1:0]  kind;
    logic [7:0]  acts = 8'h63;  // force actions 3,0,2,1
    logic [3:0]  exps = 4'b1011; // state after each force
    int          num_errors, total_checks, cyc;
    // 10 MHz system clock
    always #50 clk = ~clk;
    ocm_unit #(.WIDTH(16)) DUT (.SYS_CLK(clk), .RST(rst), .CE(ce), .TIMER_COUNT(cnt), .TIMER_TICK(tick),
        .TIMER_TOP(top), .TIMER_BOTTOM(bot), .TIMER_COUNT_WR(cnt_wr), .CAPTURE_VALUE(cap),
        .WAVEFORM_SELECT(ws), .OUTPUT_ACTION_BITS(act), .COMPARE_IRQ_ENABLE(ien), .COMPARE_IRQ_ACK(ack),
        .CPU_DATA(data), .COMPARE_VALUE_HIGH_WR(hw), .COMPARE_VALUE_LOW_WR(lw), .FLAG_WRITE(fw),
        .FORCE_COMPARE_STROBE(fo), .PORT_VALUE(pv), .COMPARE_PIN_DIRECTION_BIT(dir),
        .COMPARE_VALUE_HIGH_A(ha), .COMPARE_VALUE_LOW_A(la), .COMPARE_VALUE_HIGH_B(hb),
        .COMPARE_VALUE_LOW_B(lb), .COMPARE_VALUE_HIGH_C(hc), .COMPARE_VALUE_LOW_C(lc),
        .COMPARE_MATCH_FLAG(flag), .COMPARE_IRQ(irq), .COMPARE_OUTPUT_STATE(st), .TOP_VALUE(top_val),
        .CLEAR_ON_MATCH(clr), .PIN_OUT(pout), .PIN_OE(poe));
    ocm_cpu_model u_cpu (.clk(clk), .req(req), .kind(kind), .sel(sel), .dat(dat), .data(data),
        .hi_wr(hw), .lo_wr(lw), .flag_wr(fw), .force_wr(fo));
    // compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // let n falling edges pass
    task automatic nclk(input int n);
        repeat (n) @(negedge clk);
    endtask
    // one byte strobe through the partner
    task automatic cpu(input logic [1:0] k, input logic [2:0] s, input logic [7:0] d);
        @(negedge clk);
        {req, kind, sel, dat} <= {1'b1, k, s, d};
        @(negedge clk);
        req <= 1'b0;
    endtask
    // 16-bit value, high byte first
    task automatic wr16(input logic [2:0] s, input logic [15:0] v);
        cpu(2'h0, s, v[15:8]);
        cpu(2'h1, s, v[7:0]);
        nclk(3);
    endtask
    // one timer clock pulse
    task automatic tk();
        @(negedge clk);
        tick <= 1'b1;
        @(negedge clk);
        tick <= 1'b0;
    endtask
    // equality on one tick, then the tick that acts on it
    task automatic mt(input logic [15:0] v);
        cnt <= v;
        tk();
        cnt <= 16'h0000;
        tk();
        nclk(2);
    endtask
    // read-back of one channel
    function automatic logic [15:0] rd(input logic [1:0] i);
        return (i == 2'h0) ? {ha, la} : (i == 2'h1) ? {hb, lb} : {hc, lc};
    endfunction
    // counts, verdict, end of run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            print_verdict();
        end
    end
    // test sequence
    initial begin
        {clk, tick, top, bot, cnt_wr, cnt, ws, act, ien, ack, pv, dir, req, kind, sel, dat} = '0;
        {rst, ce, cap} = {1'b1, 1'b1, 16'h00f0};
        nclk(3);
        rst <= 1'b0;
        nclk(1);
        chk(st, 3'h0);
        chk(top_val, 16'hffff);
        $display("reset test done");
        for (logic [1:0] i = 0; i < 3; i++) begin
            wr16(3'h1 << i, 16'h1234 + 16'h1111 * i);
            chk(rd(i), 16'h1234 + 16'h1111 * i);
        end
        ws <= 4'h4;
        nclk(3);
        chk(top_val, 16'h1234);
        ws <= 4'hc;
        nclk(2);
        chk(top_val, 16'h00f0);
        ws <= 4'h4;
        $display("value test done");
        {act, ien} <= {6'h01, 3'h1};
        cnt <= 16'h1234;
        tk();
        cnt <= 16'h0000;
        chk(flag, 3'h0);
        chk(clr, 1'b1);
        tk();
        nclk(2);
        chk({irq, flag, st}, {3'h1, 3'h1, 3'h1});
        ack <= 3'h1;
        nclk(1);
        ack <= 3'h0;
        nclk(2);
        chk(flag, 3'h0);
        mt(16'h1234);
        chk(st, 3'h0);
        cpu(2'h2, 3'h1, 8'h00);
        nclk(2);
        chk(flag, 3'h1);
        cpu(2'h2, 3'h1, 8'h01);
        nclk(2);
        chk(flag, 3'h0);
        // count write while stopped, equal to the channel A top in clear-on-match mode 4
        {cnt, cnt_wr} <= {16'h1234, 1'b1};
        nclk(1);
        cnt_wr <= 1'b0;
        nclk(5);
        chk(clr, 1'b0);
        mt(16'h1234);
        chk(flag, 3'h0);
        $display("match test done");
        ws <= 4'h0;
        for (int i = 0; i < 4; i++) begin
            act <= {4'h0, acts[2*i+:2]};
            cpu(2'h3, 3'h1, 8'h00);
            nclk(2);
            chk({flag[0], st[0]}, {1'b0, exps[i]});
        end
        dir <= 3'h1;
        nclk(2);
        chk({poe[0], pout[0]}, 2'h3);
        act <= 6'h00;
        nclk(2);
        chk({poe[0], pout[0]}, 2'h2);
        {ws, act} <= {4'hf, 6'h02};
        cpu(2'h3, 3'h1, 8'h00);
        nclk(2);
        chk(st[0], 1'b1);
        wr16(3'h1, 16'h0456);
        chk(rd(0), 16'h0456);
        chk(top_val, 16'h1234);
        bot <= 1'b1;
        tk();
        bot <= 1'b0;
        nclk(2);
        chk(top_val, 16'h0456);
        // with the enable low a full write must leave the buffer untouched
        ce <= 1'b0;
        wr16(3'h1, 16'h0789);
        ce <= 1'b1;
        nclk(2);
        chk(rd(0), 16'h0456);
        $display("pwm test done");
        print_verdict();
    end
endmodule
